// [sars_regs.sv]
// Status and negotiation register bank of one serial gigabit port.
// Assumes a classic Wishbone master and core state synchronous to clk_i.
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "sars_params.svh"
module sars_regs (
  // Clock and reset.
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // Wishbone slave.
  input  wire sars_pkg::sars_wb_req_t wb_req_i,
  output logic              [31:0] wb_dat_o,
  output logic                     wb_ack_o,
  // Core state.
  input  wire sars_pkg::sars_copper_t copper_i,
  input  wire sars_pkg::sars_serdes_t serdes_i,
  // Interrupt.
  output logic                     irq_o
);
  import sars_pkg::*;

  // Bus handshake state.
  sars_bus_st_t bus_q;
  // Latched-low link bit, done bit and enhanced control bit.
  logic         link_ll_q;
  logic         done_q;
  logic         enh_q;
  logic         lp_ack;
  logic         link_prev_q;
  logic [`SARS_IRQ_W-1:0] irq_stat;
  logic [`SARS_IRQ_W-1:0] irq_mask;

  // Index decode of a word address.
  function automatic logic hit(input logic [5:0] a, input logic [3:0] i);
    hit = (a[5:2] == i) && (a[1:0] == 2'b00);
  endfunction : hit

  // A new access is one strobe seen while no answer is pending.
  wire acc_w   = wb_req_i.cyc && wb_req_i.stb && (bus_q == SARS_IDLE);
  wire rd_w    = acc_w && !wb_req_i.we;
  wire wr_w    = acc_w && wb_req_i.we && wb_req_i.sel[0];
  wire hit_st  = hit(wb_req_i.adr, `SARS_IDX_STATUS);
  wire hit_ad  = hit(wb_req_i.adr, `SARS_IDX_ADV);
  wire hit_lp  = hit(wb_req_i.adr, `SARS_IDX_PARTNER);
  wire hit_is  = hit(wb_req_i.adr, `SARS_IDX_IRQ_STATUS);
  wire hit_im  = hit(wb_req_i.adr, `SARS_IDX_IRQ_MASK);
  wire hit_ct  = hit(wb_req_i.adr, `SARS_IDX_CONTROL);
  wire st_rd_w = rd_w && hit_st;

  // Negotiation counts as complete only on a real negotiated finish.
  wire done_w  = serdes_i.aneg_done && serdes_i.aneg_enabled &&
                 !serdes_i.bypass;
  wire drop_w  = link_prev_q && !serdes_i.link_up;

  // Status word: only bits 5 and 2 live; the rest reads zero.
  wire [15:0] st_w = {10'h000, done_q, 2'b00, link_ll_q, 2'b00};

  // Advertisement word built live from copper state.
  wire [15:0] ad_w = {copper_i.link_up, 2'b00,
                      copper_i.full_duplex,
                      copper_i.speed,
                      copper_i.tx_pause & enh_q,
                      copper_i.rx_pause & enh_q,
                      copper_i.fiber & enh_q,
                      7'h01};

  // Partner ability word carries only the acknowledge bit.
  wire [15:0] lp_w = {1'b0, lp_ack, 14'h0000};

  // Read mux; unmapped addresses read as zero and are still answered.
  wire [31:0] rdat_w =
    hit_st ? {16'h0000, st_w} :
    hit_ad ? {16'h0000, ad_w} :
    hit_lp ? {16'h0000, lp_w} :
    hit_is ? {29'h0, irq_stat} :
    hit_im ? {29'h0, irq_mask} :
    hit_ct ? {31'h0, enh_q} : 32'h0000_0000;

  // One-cycle answer; ack drops the cycle after it was given.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_q    <= SARS_IDLE;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      bus_q    <= acc_w ? SARS_ACK : SARS_IDLE;
      wb_ack_o <= acc_w;
      if (rd_w) begin
        wb_dat_o <= rdat_w;
      end
    end
  end

  // Enhanced-negotiation control; writes elsewhere are dropped, except those to interrupt status and mask.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enh_q <= `SARS_CTL_RST;
    end else if (wr_w && hit_ct) begin
      enh_q <= wb_req_i.dat[`SARS_CTL_ENH];
    end
  end

  // Latched-low link: a drop holds low, a read re-arms to live state.
  // A drop in the read cycle wins so the loss is never missed.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link_ll_q   <= 1'b0;
      link_prev_q <= 1'b0;
      done_q      <= 1'b0;
    end else begin
      link_prev_q <= serdes_i.link_up;
      done_q      <= done_w;
      if (!serdes_i.link_up) begin
        link_ll_q <= 1'b0;
      end else if (st_rd_w) begin
        link_ll_q <= 1'b1;
      end
    end
  end

  // Partner acknowledge capture.
  sars_partner u_partner (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .link_up_i (serdes_i.link_up),
    .page_rx_i (serdes_i.page_rx),
    .ack_bit_i (serdes_i.page_word[`SARS_LP_ACK]),
    .ack_o     (lp_ack)
  );

  // Events: link drop, negotiation finish rising, base page arrival.
  wire [`SARS_IRQ_W-1:0] ev_w = {serdes_i.page_rx,
                                 done_w && !done_q,
                                 drop_w};

  sars_irq u_irq (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .event_i   (ev_w),
    .clr_we_i  (wr_w && hit_is),
    .mask_we_i (wr_w && hit_im),
    .wdata_i   (wb_req_i.dat[`SARS_IRQ_W-1:0]),
    .status_o  (irq_stat),
    .mask_o    (irq_mask),
    .irq_o     (irq_o)
  );

  // Bypass or disabled negotiation keeps the done bit clear a cycle later.
  property p_done_follow;
    @(posedge clk_i) disable iff (rst_i)
      (serdes_i.bypass || !serdes_i.aneg_enabled) |=> !done_q;
  endproperty
  a_done_follow: assert property (p_done_follow)
    else $error("done bit set under bypass or disabled");

  property p_done_set;
    @(posedge clk_i) disable iff (rst_i)
      done_w |=> done_q;
  endproperty
  a_done_set: assert property (p_done_set)
    else $error("done bit missed completion");

  // Link loss holds the bit low until a status read with link up.
  sequence s_drop;
    !serdes_i.link_up;
  endsequence
  property p_link_ll;
    @(posedge clk_i) disable iff (rst_i)
      s_drop ##1 (!st_rd_w)[*2] |=> !link_ll_q;
  endproperty
  a_link_ll: assert property (p_link_ll)
    else $error("link bit rose without a read");

  property p_link_rearm;
    @(posedge clk_i) disable iff (rst_i)
      (st_rd_w && serdes_i.link_up) |=> link_ll_q;
  endproperty
  a_link_rearm: assert property (p_link_rearm)
    else $error("link bit not re-armed by read");

  property p_adv_link;
    @(posedge clk_i) disable iff (rst_i)
      rd_w && hit_ad |=>
        wb_dat_o[`SARS_AD_LINK] == $past(copper_i.link_up) &&
        wb_dat_o[`SARS_AD_DUPLEX] == $past(copper_i.full_duplex);
  endproperty
  a_adv_link: assert property (p_adv_link)
    else $error("link or duplex advertised wrong");

  property p_adv_speed;
    @(posedge clk_i) disable iff (rst_i)
      rd_w && hit_ad |=>
        wb_dat_o[`SARS_AD_SPEED_HI:`SARS_AD_SPEED_LO] ==
        $past(copper_i.speed);
  endproperty
  a_adv_speed: assert property (p_adv_speed)
    else $error("speed field read back wrong");

  property p_adv_enh;
    @(posedge clk_i) disable iff (rst_i)
      rd_w && hit_ad && !enh_q |=>
        wb_dat_o[`SARS_AD_TX_PAUSE:`SARS_AD_MEDIA] == 3'h0;
  endproperty
  a_adv_enh: assert property (p_adv_enh)
    else $error("pause or media not forced low");

  property p_ack_drop;
    @(posedge clk_i) disable iff (rst_i)
      !serdes_i.link_up |=> !lp_ack;
  endproperty
  a_ack_drop: assert property (p_ack_drop)
    else $error("ack not cleared on link loss");

  property p_ack_load;
    @(posedge clk_i) disable iff (rst_i)
      (serdes_i.page_rx && serdes_i.link_up) |=>
        lp_ack == $past(serdes_i.page_word[`SARS_LP_ACK]);
  endproperty
  a_ack_load: assert property (p_ack_load)
    else $error("ack not loaded from code word");

  property p_rsvd;
    @(posedge clk_i) disable iff (rst_i)
      rd_w && (hit_st || hit_lp) |=>
        (wb_dat_o & 32'hffff_bfdb) == 32'h0000_0000 && wb_ack_o;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved bits not zero");

  // Every taken access is answered once, next cycle, then ack drops.
  sequence s_answer;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  property p_ack_walk;
    @(posedge clk_i) disable iff (rst_i)
      acc_w |=> s_answer;
  endproperty
  a_ack_walk: assert property (p_ack_walk)
    else $error("bus answer not a single next-cycle pulse");

  // Read data stands until the next read replaces it.
  property p_dat_hold;
    @(posedge clk_i) disable iff (rst_i)
      !rd_w |=> $stable(wb_dat_o);
  endproperty
  a_dat_hold: assert property (p_dat_hold)
    else $error("read data changed without a read");

  // A control write loads the enhanced-negotiation bit.
  property p_ctl_write;
    @(posedge clk_i) disable iff (rst_i)
      (wr_w && hit_ct) |=> enh_q == $past(wb_req_i.dat[`SARS_CTL_ENH]);
  endproperty
  a_ctl_write: assert property (p_ctl_write)
    else $error("control write not taken");

  // Writes elsewhere never disturb the control bit.
  property p_ctl_hold;
    @(posedge clk_i) disable iff (rst_i)
      (wr_w && !hit_ct) |=> $stable(enh_q);
  endproperty
  a_ctl_hold: assert property (p_ctl_hold)
    else $error("control bit changed by another write");

  // The acknowledge holds between pages while the link stays up.
  property p_ack_hold;
    @(posedge clk_i) disable iff (rst_i)
      (serdes_i.link_up && !serdes_i.page_rx) |=> $stable(lp_ack);
  endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("ack changed without a page");

  // Each event sets its sticky bit; a clear in the same cycle loses.
  property p_ev_drop;
    @(posedge clk_i) disable iff (rst_i)
      drop_w |=> irq_stat[`SARS_IRQ_LINK_DOWN];
  endproperty
  a_ev_drop: assert property (p_ev_drop)
    else $error("link drop event not recorded");

  property p_ev_done;
    @(posedge clk_i) disable iff (rst_i)
      (done_w && !done_q) |=> irq_stat[`SARS_IRQ_ANEG_DONE];
  endproperty
  a_ev_done: assert property (p_ev_done)
    else $error("negotiation done event not recorded");

  property p_ev_page;
    @(posedge clk_i) disable iff (rst_i)
      serdes_i.page_rx |=> irq_stat[`SARS_IRQ_PAGE_RX];
  endproperty
  a_ev_page: assert property (p_ev_page)
    else $error("page event not recorded");

  // The level output follows the unmasked status bits.
  property p_irq_level;
    @(posedge clk_i) disable iff (rst_i)
      irq_o == |(irq_stat & irq_mask);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt level does not match status and mask");

endmodule : sars_regs
`default_nettype wire

// [sars_params.svh]
// Offsets, field positions, reset values and reserved patterns for the
// serial port status and negotiation register bank.
// Assumes a 40 MHz clock and a classic Wishbone slave with 32-bit data.
`ifndef SARS_PARAMS_SVH
`define SARS_PARAMS_SVH

// Printed register indices; the byte address is four times the index.
`define SARS_IDX_STATUS      4'h1
`define SARS_IDX_ADV         4'h4
`define SARS_IDX_PARTNER     4'h5
`define SARS_IDX_IRQ_STATUS  4'h8
`define SARS_IDX_IRQ_MASK    4'h9
`define SARS_IDX_CONTROL     4'ha

// Status register field positions.
`define SARS_ST_ANEG_DONE    5
`define SARS_ST_LINK         2

// Advertisement register field positions.
`define SARS_AD_LINK         15
`define SARS_AD_DUPLEX       12
`define SARS_AD_SPEED_HI     11
`define SARS_AD_SPEED_LO     10
`define SARS_AD_TX_PAUSE     9
`define SARS_AD_RX_PAUSE     8
`define SARS_AD_MEDIA        7

// Partner ability field position, also its position in the code word.
`define SARS_LP_ACK          14

// Reset values and constant reserved patterns.
`define SARS_RST_STATUS      16'h0000
`define SARS_RST_ADV         16'h0001
`define SARS_RST_PARTNER     16'h0000
`define SARS_ADV_RSVD        16'h0001

// Interrupt bit positions in status and mask registers.
`define SARS_IRQ_LINK_DOWN   0
`define SARS_IRQ_ANEG_DONE   1
`define SARS_IRQ_PAGE_RX     2
`define SARS_IRQ_W           3

// Control register bit: enhanced negotiation enable.
`define SARS_CTL_ENH         0
`define SARS_CTL_RST         1'h1

`endif

// [sars_pkg.sv]
// Types shared by the status and negotiation register bank.
// Assumes the constants header sits in the same folder.
package sars_pkg;

  // Copper-side state resolved by the transceiver core.
  typedef struct packed {
    logic       link_up;
    logic       full_duplex;
    logic [1:0] speed;
    logic       tx_pause;
    logic       rx_pause;
    logic       fiber;
  } sars_copper_t;

  // Serial negotiation events from the link state machine.
  typedef struct packed {
    logic        link_up;
    logic        aneg_enabled;
    logic        aneg_done;
    logic        bypass;
    logic        page_rx;
    logic [15:0] page_word;
  } sars_serdes_t;

  // Wishbone request bundle.
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [5:0]  adr;
    logic [31:0] dat;
  } sars_wb_req_t;

  // Bus access decode state.
  typedef enum logic [0:0] {
    SARS_IDLE = 1'b0,
    SARS_ACK  = 1'b1
  } sars_bus_st_t;

endpackage : sars_pkg

// [sars_irq.sv]
// Sticky interrupt status with mask and one level output.
// Assumes event pulses and write-one-to-clear strobes on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "sars_params.svh"
module sars_irq (
  // Clock and reset.
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  // Events and software access.
  input  wire logic [`SARS_IRQ_W-1:0] event_i,
  input  wire logic                   clr_we_i,
  input  wire logic                   mask_we_i,
  input  wire logic [`SARS_IRQ_W-1:0] wdata_i,
  // Results.
  output logic      [`SARS_IRQ_W-1:0] status_o,
  output logic      [`SARS_IRQ_W-1:0] mask_o,
  output logic                        irq_o
);
  import sars_pkg::*;

  // Clear mask; a new event in the same cycle wins over the clear.
  wire [`SARS_IRQ_W-1:0] clr_w  = clr_we_i ? wdata_i : '0;
  wire [`SARS_IRQ_W-1:0] stat_d = (status_o & ~clr_w) | event_i;

  // Status, mask and the registered interrupt level.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_o <= '0;
      mask_o   <= '0;
      irq_o    <= 1'b0;
    end else begin
      status_o <= stat_d;
      if (mask_we_i) begin
        mask_o <= wdata_i;
      end
      irq_o <= |(stat_d & (mask_we_i ? wdata_i : mask_o));
    end
  end

endmodule : sars_irq
`default_nettype wire

// [sars_partner.sv]
// Partner acknowledge capture from the received base page.
// Assumes page_rx is a one-cycle pulse with the code word valid alongside.
`timescale 1ns/1ps
`default_nettype none
`include "sars_params.svh"
module sars_partner (
  // Clock and reset.
  input  wire logic  clk_i,
  input  wire logic  rst_i,
  // Link events.
  input  wire logic  link_up_i,
  input  wire logic  page_rx_i,
  input  wire logic  ack_bit_i,
  // Captured acknowledge.
  output logic       ack_o
);
  import sars_pkg::*;

  // Link loss clears; a page with link up loads the received bit.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else if (!link_up_i) begin
      ack_o <= 1'b0;
    end else if (page_rx_i) begin
      ack_o <= ack_bit_i;
    end
  end

endmodule : sars_partner
`default_nettype wire

// [sars_link_model.sv]
// Behavioural serial link side: presents negotiation state and pages.
// Assumes the bench drives its requests just after the rising edge.
`timescale 1ns/1ps
`default_nettype none
module sars_link_model (
  // Clock and reset.
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  // Requested link state.
  input  wire logic                   link_i,
  input  wire logic                   aneg_en_i,
  input  wire logic                   done_i,
  input  wire logic                   bypass_i,
  input  wire logic                   page_i,
  input  wire logic            [15:0] word_i,
  // Serial state seen by the block.
  output var  sars_pkg::sars_serdes_t serdes_o
);
  import sars_pkg::*;
  logic        page_q; // One-cycle page strobe.
  logic [15:0] word_q; // Code word, valid with the strobe only.
  // Off the strobe the word toggles, so a stale value never helps.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      page_q <= 1'b0;
      word_q <= 16'h0000;
    end else begin
      page_q <= page_i;
      word_q <= page_i ? word_i : ~word_q;
    end
  end
  assign serdes_o = '{link_up: link_i, aneg_enabled: aneg_en_i,
    aneg_done: done_i, bypass: bypass_i, page_rx: page_q, page_word: word_q};
endmodule : sars_link_model
`default_nettype wire

// [tb.sv]
// Self-checking bench for the port status register bank.
// Assumes the link model in the same folder drives the serial state.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sars_pkg::*;
  logic         clk_i, rst_i, wb_ack_o, irq_o;
  logic  [31:0] wb_dat_o, q;
  sars_wb_req_t req;
  sars_copper_t copper;
  sars_serdes_t serdes;
  logic         link, aneg_en, done, bypass, page;
  logic  [15:0] word;
  int           bad_count, checks;
  // Clock at 40 MHz.
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  sars_regs uut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .copper_i(copper),
    .serdes_i(serdes), .irq_o(irq_o));
  sars_link_model link_m (.clk_i(clk_i), .rst_i(rst_i), .link_i(link),
    .aneg_en_i(aneg_en), .done_i(done), .bypass_i(bypass),
    .page_i(page), .word_i(word), .serdes_o(serdes));
  // Counts every comparison and reports a mismatch at once.
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One classic cycle; entered and left on a rising edge.
  task automatic wb(input logic we, input logic [5:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: a, dat: d};
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) begin
      @(posedge clk_i);
      n++;
    end
    chk("ack delay", 32'h1, 32'(n));
    q = wb_dat_o;
    req <= '0;
    @(posedge clk_i);
  endtask : wb
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_i);
  endtask : wait_n
  // Expected advertisement word for the given copper state.
  function automatic logic [31:0] adv(input sars_copper_t c, input logic e);
    return {16'h0000, c.link_up, 2'b00, c.full_duplex, c.speed,
            c.tx_pause & e, c.rx_pause & e, c.fiber & e, 7'h01};
  endfunction : adv
  // Reset values, an unmapped place, and an ignored status write.
  task automatic t_reset();
    wb(1'b0, 6'h04, 32'h0); chk("status", 32'h0, q);
    wb(1'b0, 6'h10, 32'h0); chk("adv", 32'h1, q);
    wb(1'b0, 6'h14, 32'h0); chk("partner", 32'h0, q);
    wb(1'b0, 6'h28, 32'h0); chk("control", 32'h1, q);
    wb(1'b0, 6'h3c, 32'h0); chk("unmapped", 32'h0, q);
    wb(1'b1, 6'h04, 32'hffff);
    wb(1'b0, 6'h04, 32'h0); chk("status wr", 32'h0, q);
    $display("test reset done");
  endtask : t_reset
  // Every speed code, with enhanced negotiation on and then off.
  task automatic t_adv();
    for (int e = 1; e >= 0; e--) begin
      wb(1'b1, 6'h28, 32'(e));
      for (int i = 0; i < 4; i++) begin
        copper <= '{link_up: i[0], full_duplex: i[1], speed: 2'(i),
                    tx_pause: 1'b1, rx_pause: ~i[0], fiber: i[1]};
        wait_n(2);
        wb(1'b0, 6'h10, 32'h0);
        chk("adv", adv(copper, e[0]), q);
      end
    end
    wb(1'b1, 6'h10, 32'h0);
    wb(1'b0, 6'h10, 32'h0); chk("adv wr", adv(copper, 1'b0), q);
    wb(1'b1, 6'h28, 32'h1);
    $display("test adv done");
  endtask : t_adv
  // Latched-low link bit needs a second read to show the present state.
  task automatic t_link();
    link <= 1'b1;
    wait_n(3);
    wb(1'b0, 6'h04, 32'h0); chk("link 1st", 32'h0, q & 32'h4);
    wb(1'b0, 6'h04, 32'h0); chk("link 2nd", 32'h4, q & 32'h4);
    link <= 1'b0;
    wait_n(2);
    link <= 1'b1;
    wait_n(3);
    wb(1'b0, 6'h04, 32'h0); chk("link drop", 32'h0, q & 32'h4);
    wb(1'b0, 6'h04, 32'h0); chk("link back", 32'h4, q & 32'h4);
    $display("test link done");
  endtask : t_link
  // Negotiation complete only when enabled, done and not bypassed.
  task automatic t_done();
    logic [2:0] cs [4] = '{3'b110, 3'b111, 3'b010, 3'b100};
    foreach (cs[i]) begin
      {aneg_en, done, bypass} <= cs[i];
      wait_n(3);
      wb(1'b0, 6'h04, 32'h0);
      chk("done", 32'(cs[i] == 3'b110), 32'(q[5]));
    end
    $display("test done bit done");
  endtask : t_done
  // Sends one base page with the given code word.
  task automatic send(input logic [15:0] w);
    word <= w;
    page <= 1'b1;
    @(posedge clk_i);
    page <= 1'b0;
    wait_n(3);
    wb(1'b0, 6'h14, 32'h0);
  endtask : send
  // Acknowledge loads from word bit 14 and clears on link loss.
  task automatic t_partner();
    send(16'h4000); chk("ack set", 32'h4000, q);
    send(16'hbfff); chk("ack clr", 32'h0, q);
    send(16'h4000);
    link <= 1'b0;
    wait_n(3);
    wb(1'b0, 6'h14, 32'h0); chk("ack down", 32'h0, q);
    send(16'h4000); chk("ack link dn", 32'h0, q);
    $display("test partner done");
  endtask : t_partner
  // Link-drop event: raise, mask, unmask, clear; then done and page events while masked.
  task automatic t_irq();
    link <= 1'b1;
    wb(1'b1, 6'h20, 32'h7);
    wb(1'b1, 6'h24, 32'h1);
    chk("irq idle", 32'h0, 32'(irq_o));
    link <= 1'b0;
    wait_n(3);
    chk("irq up", 32'h1, 32'(irq_o));
    wb(1'b0, 6'h20, 32'h0); chk("irq st", 32'h1, q & 32'h1);
    wb(1'b1, 6'h24, 32'h0);
    wait_n(2);
    chk("irq masked", 32'h0, 32'(irq_o));
    wb(1'b1, 6'h24, 32'h1);
    wait_n(2);
    chk("irq unmask", 32'h1, 32'(irq_o));
    wb(1'b1, 6'h20, 32'h1);
    wait_n(2);
    chk("irq clr", 32'h0, 32'(irq_o));
    wb(1'b0, 6'h20, 32'h0); chk("irq st clr", 32'h0, q & 32'h1);
    done <= 1'b1;
    wait_n(3);
    send(16'h0000);
    wb(1'b0, 6'h20, 32'h0); chk("irq st ev", 32'h6, q & 32'h7);
    chk("irq ev masked", 32'h0, 32'(irq_o));
    wb(1'b1, 6'h20, 32'h6);
    wb(1'b0, 6'h20, 32'h0); chk("irq st ev clr", 32'h0, q & 32'h7);
    $display("test irq done");
  endtask : t_irq
  // The single place where the run ends.
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  // Watchdog well beyond the few hundred cycles the tests need.
  initial begin
    wait_n(20000);
    bad_count++;
    finish_test();
  end
  initial begin
    rst_i = 1'b1;
    {req, copper, link, aneg_en, done, bypass, page, word} = '0;
    {bad_count, checks} = '0;
    wait_n(20);
    rst_i <= 1'b0;
    t_reset();
    t_adv();
    t_link();
    t_done();
    t_partner();
    t_irq();
    finish_test();
  end
endmodule : tb
`default_nettype wire
